//--- logic/ddsr_consts.vh
// constants for the drive diagnostic status register bank
`ifndef DDSR_CONSTS_VH
`define DDSR_CONSTS_VH
// ==========================================
// register addresses
`define DDSR_ADDR_DOS 6'h11
`define DDSR_ADDR_GFI 6'h12
`define DDSR_ADDR_CF1 6'h13
`define DDSR_ADDR_CF6 6'h18
`define DDSR_ADDR_TR_LO 6'h19
`define DDSR_ADDR_TR_HI 6'h1C
`define DDSR_ADDR_CMD1 6'h01
// ==========================================
// dynamic output state fields
`define DDSR_DOS_UV 15
`define DDSR_DOS_ST_HI 14
`define DDSR_DOS_ST_LO 13
`define DDSR_DOS_EXT_HI 12
`define DDSR_DOS_EXT_LO 11
`define DDSR_DOS_OUT_HI 10
`define DDSR_DOS_OUT_LO 5
`define DDSR_DOS_EF_HI 4
`define DDSR_DOS_EF_LO 1
// ==========================================
// general fault fields
`define DDSR_GFI_CP 15
`define DDSR_GFI_LVI 14
`define DDSR_GFI_OV 13
`define DDSR_GFI_TSD_HI 12
`define DDSR_GFI_TSD_LO 7
`define DDSR_GFI_TW_HI 6
`define DDSR_GFI_TW_LO 1
// ==========================================
// feedback fields
`define DDSR_CF_AUX 15
`define DDSR_CF_HI 10
`define DDSR_CF_LO 1
// ==========================================
// codes
`define DDSR_EF_NONE 2'h0
`define DDSR_EF_LS 2'h1
`define DDSR_EF_HS 2'h2
`define DDSR_ST_READY 2'h0
`define DDSR_ST_ACT 2'h1
`define DDSR_ST_BRAKE 2'h2
`define DDSR_ST_DONE 2'h3
`define DDSR_BRK_INDEF 2'h3
// ==========================================
// timing
`define DDSR_CLK_MHZ 200
`define DDSR_DONE_MS 100
`define DDSR_DONE_CYC (`DDSR_DONE_MS * 1000 * `DDSR_CLK_MHZ)
`define DDSR_FILT_CYC 8'h10
`define DDSR_BLANK_STEP 8'h20
`endif

//--- logic/ddsr_fb_mem.v
// feedback value store, six 10-bit words, registered read
`timescale 1ns/1ps
`default_nettype none
module ddsr_fb_mem (
	input wire i_clk,
	input wire i_nrst,
	input wire i_we,
	input wire [2:0] i_waddr,
	input wire [9:0] i_wdata,
	input wire [2:0] i_raddr,
	output reg [9:0] o_rdata
);
	reg [9:0] mem [0:5];
	integer k;
	always @(posedge i_clk) begin
		if (!i_nrst) begin
			for (k = 0; k < 6; k = k + 1)
				mem[k] <= 10'h000;
			o_rdata <= 10'h000;
		end else begin
			if (i_we && i_waddr < 3'h6)
				mem[i_waddr] <= i_wdata;
			o_rdata <= (i_raddr < 3'h6) ? mem[i_raddr] : 10'h000;
		end
	end
endmodule
`default_nettype wire

//--- logic/ddsr_top.v
// diagnostic and status register bank of a multi-output actuator driver
`timescale 1ns/1ps
`default_nettype none
`include "ddsr_consts.vh"
module ddsr_top #(
	parameter DONE_CYCLES = `DDSR_DONE_CYC
) (
	input wire i_clk,
	input wire i_nrst,
	input wire i_csn,
	input wire i_rd,
	input wire i_rc,
	input wire i_wr,
	input wire [5:0] i_addr,
	input wire [15:0] i_rc_mask,
	output reg [15:0] o_rdata,
	input wire [1:0] i_ext_on,
	input wire [1:0] i_ext_vds_hi,
	input wire [1:0] i_ext_vds_side,
	input wire [3:0] i_blank_setting,
	input wire [1:0] i_ext_level,
	input wire [5:0] i_out_level,
	input wire [5:0] i_override,
	input wire i_emerg_override,
	input wire i_seq_active,
	input wire i_seq_braking,
	input wire i_seq_done,
	input wire [1:0] i_brake_setting,
	input wire i_logic_uv,
	input wire i_aux_uv,
	input wire i_bat_ov,
	input wire i_bat_lvi,
	input wire i_pump_low,
	input wire [5:0] i_tw_set,
	input wire [5:0] i_tw_hold,
	input wire [5:0] i_tsd_set,
	input wire [5:0] i_tsd_hold,
	input wire i_scope_select,
	input wire i_fb_we,
	input wire [2:0] i_fb_sel,
	input wire [9:0] i_fb_value,
	output wire o_global_supply_fault,
	output reg [1:0] o_ext_off,
	output reg [5:0] o_out_off,
	output reg o_device_off
);
	// ==========================================
	// pin synchronisers
	reg csn_s1, csn_s2;
	reg csn_d;
	reg [7:0] lvl_s1, lvl_s2;
	reg [4:0] sup_s1, sup_s2;
	reg [23:0] th_s1, th_s2;
	reg [3:0] vds_s1, vds_s2;
	always @(posedge i_clk) begin
		if (!i_nrst) begin
			csn_s1 <= 1'b1;
			csn_s2 <= 1'b1;
			csn_d <= 1'b1;
			lvl_s1 <= 8'h00;
			lvl_s2 <= 8'h00;
			sup_s1 <= 5'h00;
			sup_s2 <= 5'h00;
			th_s1 <= 24'h000000;
			th_s2 <= 24'h000000;
			vds_s1 <= 4'h0;
			vds_s2 <= 4'h0;
		end else begin
			csn_s1 <= i_csn;
			csn_s2 <= csn_s1;
			csn_d <= csn_s2;
			lvl_s1 <= {i_ext_level, i_out_level};
			lvl_s2 <= lvl_s1;
			sup_s1 <= {i_pump_low, i_bat_lvi, i_bat_ov, i_aux_uv, i_logic_uv};
			sup_s2 <= sup_s1;
			th_s1 <= {i_tsd_hold, i_tsd_set, i_tw_hold, i_tw_set};
			th_s2 <= th_s1;
			vds_s1 <= {i_ext_vds_side, i_ext_vds_hi};
			vds_s2 <= vds_s1;
		end
	end
	wire csn_fall = csn_d & ~csn_s2;
	wire [5:0] tw_set = th_s2[5:0];
	wire [5:0] tw_hold = th_s2[11:6];
	wire [5:0] tsd_set = th_s2[17:12];
	wire [5:0] tsd_hold = th_s2[23:18];

	// ==========================================
	// clear decode
	wire rc_dos = i_rc && (i_addr == `DDSR_ADDR_DOS);
	wire rc_gfi = i_rc && (i_addr == `DDSR_ADDR_GFI);
	wire rc_cf1 = i_rc && (i_addr == `DDSR_ADDR_CF1);
	wire [15:0] clr_dos = rc_dos ? i_rc_mask : 16'h0000;
	wire [15:0] clr_gfi = rc_gfi ? i_rc_mask : 16'h0000;

	// ==========================================
	// external drain-source monitor
	reg [1:0] on_d;
	reg [7:0] vds_cnt [0:1];
	reg [7:0] blank_cnt [0:1];
	reg [3:0] ext_code_reg;
	integer e;
	always @(posedge i_clk) begin
		if (!i_nrst) begin
			on_d <= 2'h0;
			ext_code_reg <= 4'h0;
			o_ext_off <= 2'h0;
			for (e = 0; e < 2; e = e + 1) begin
				vds_cnt[e] <= 8'h00;
				blank_cnt[e] <= 8'h00;
			end
		end else begin
			on_d <= i_ext_on;
			for (e = 0; e < 2; e = e + 1) begin
				if (clr_dos[`DDSR_DOS_EF_LO + 2*e])
					ext_code_reg[2*e] <= 1'b0;
				if (clr_dos[`DDSR_DOS_EF_LO + 2*e + 1])
					ext_code_reg[2*e+1] <= 1'b0;
				if (!i_ext_on[e]) begin
					o_ext_off[e] <= 1'b0;
					vds_cnt[e] <= 8'h00;
				end
				if (i_ext_on[e] && !on_d[e]) begin
					// blanking grows in fixed steps per setting code
					blank_cnt[e] <= {6'h00, i_blank_setting[2*e+1 -: 2]} * `DDSR_BLANK_STEP;
				end else if (blank_cnt[e] != 8'h00) begin
					blank_cnt[e] <= blank_cnt[e] - 8'h01;
				end
				if (i_ext_on[e] && blank_cnt[e] == 8'h00 && !o_ext_off[e]) begin
					if (vds_s2[e]) begin
						if (vds_cnt[e] == `DDSR_FILT_CYC) begin
							o_ext_off[e] <= 1'b1;
							ext_code_reg[2*e+1 -: 2] <= vds_s2[2+e] ?
								`DDSR_EF_HS : `DDSR_EF_LS;
						end else begin
							vds_cnt[e] <= vds_cnt[e] + 8'h01;
						end
					end else begin
						vds_cnt[e] <= 8'h00;
					end
				end
			end
		end
	end

	// ==========================================
	// output level sample at chip-select fall
	reg [7:0] level_reg;
	always @(posedge i_clk) begin
		if (!i_nrst)
			level_reg <= 8'h00;
		else if (csn_fall)
			level_reg <= lvl_s2;
	end

	// ==========================================
	// actuation status
	reg [1:0] stat_reg, stat_next;
	reg [31:0] done_cnt;
	wire seq_owned = (i_override != 6'h3F);
	wire indef = (i_brake_setting == `DDSR_BRK_INDEF);
	always @* begin
		stat_next = stat_reg;
		case (stat_reg)
			`DDSR_ST_READY: if (seq_owned && i_seq_active) stat_next = `DDSR_ST_ACT;
			`DDSR_ST_ACT: if (seq_owned && i_seq_braking) stat_next = `DDSR_ST_BRAKE;
			`DDSR_ST_BRAKE: begin
				if (indef ? (done_cnt == DONE_CYCLES - 1) : (seq_owned && i_seq_done))
					stat_next = `DDSR_ST_DONE;
			end
			`DDSR_ST_DONE: stat_next = `DDSR_ST_DONE;
			default: stat_next = `DDSR_ST_READY;
		endcase
		if (clr_dos[`DDSR_DOS_ST_HI] && clr_dos[`DDSR_DOS_ST_LO])
			stat_next = `DDSR_ST_READY;
		else if (clr_dos[`DDSR_DOS_ST_HI])
			stat_next = {1'b0, stat_reg[0]};
		else if (clr_dos[`DDSR_DOS_ST_LO])
			stat_next = {stat_reg[1], 1'b0};
		if (i_emerg_override && i_wr && i_addr == `DDSR_ADDR_CMD1)
			stat_next = `DDSR_ST_READY;
	end
	always @(posedge i_clk) begin
		if (!i_nrst) begin
			stat_reg <= `DDSR_ST_READY;
			done_cnt <= 32'h00000000;
		end else begin
			stat_reg <= stat_next;
			if (stat_reg == `DDSR_ST_BRAKE)
				done_cnt <= done_cnt + 32'h00000001;
			else
				done_cnt <= 32'h00000000;
		end
	end

	// ==========================================
	// supply and thermal latches; set wins over clear
	reg logic_uv_reg, aux_uv_reg, ov_reg, lvi_reg, pump_reg;
	reg [5:0] tw_reg, tsd_reg;
	always @(posedge i_clk) begin
		if (!i_nrst) begin
			logic_uv_reg <= 1'b0;
			aux_uv_reg <= 1'b0;
			ov_reg <= 1'b0;
			lvi_reg <= 1'b0;
			pump_reg <= 1'b0;
			tw_reg <= 6'h00;
			tsd_reg <= 6'h00;
		end else begin
			logic_uv_reg <= sup_s2[0] | (logic_uv_reg & ~clr_dos[`DDSR_DOS_UV]);
			aux_uv_reg <= sup_s2[1] | (aux_uv_reg & ~(rc_cf1 & i_rc_mask[`DDSR_CF_AUX]));
			ov_reg <= sup_s2[2] | (ov_reg & ~clr_gfi[`DDSR_GFI_OV]);
			lvi_reg <= sup_s2[3] | (lvi_reg & ~clr_gfi[`DDSR_GFI_LVI]);
			pump_reg <= sup_s2[4] | (pump_reg & ~clr_gfi[`DDSR_GFI_CP]);
			// hold inputs keep a flag alive above the reset threshold
			tw_reg <= tw_set | (tw_reg & (tw_hold |
				~clr_gfi[`DDSR_GFI_TW_HI:`DDSR_GFI_TW_LO]));
			tsd_reg <= tsd_set | (tsd_reg & (tsd_hold |
				~clr_gfi[`DDSR_GFI_TSD_HI:`DDSR_GFI_TSD_LO]));
		end
	end
	assign o_global_supply_fault = logic_uv_reg | aux_uv_reg;

	always @(posedge i_clk) begin
		if (!i_nrst) begin
			o_out_off <= 6'h00;
			o_device_off <= 1'b0;
		end else begin
			o_out_off <= i_scope_select ? 6'h00 : tsd_reg;
			o_device_off <= i_scope_select & (|tsd_reg);
		end
	end

	// ==========================================
	// feedback store
	wire [9:0] fb_rdata;
	wire [2:0] fb_raddr = i_addr[2:0] - 3'h3;
	ddsr_fb_mem u_fb (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_we(i_fb_we),
		.i_waddr(i_fb_sel),
		.i_wdata(i_fb_value),
		.i_raddr(fb_raddr),
		.o_rdata(fb_rdata)
	);

	// ==========================================
	// read path, two cycles behind the request; parity is odd
	function [15:0] ddsr_par;
		input [15:1] d;
		ddsr_par = {d, ~(^d)};
	endfunction
	reg rd_d;
	reg [5:0] addr_d;
	reg [15:0] dos_snap, gfi_snap;
	reg aux_snap;
	always @(posedge i_clk) begin
		if (!i_nrst) begin
			rd_d <= 1'b0;
			addr_d <= 6'h00;
			dos_snap <= 16'h0000;
			gfi_snap <= 16'h0000;
			aux_snap <= 1'b0;
		end else begin
			rd_d <= i_rd | i_rc;
			addr_d <= i_addr;
			// content taken before the clear lands
			dos_snap <= ddsr_par({logic_uv_reg, stat_reg, level_reg, ext_code_reg});
			gfi_snap <= ddsr_par({pump_reg, lvi_reg, ov_reg, tsd_reg, tw_reg});
			aux_snap <= aux_uv_reg;
		end
	end
	always @(posedge i_clk) begin
		if (!i_nrst) begin
			o_rdata <= 16'h0000;
		end else if (rd_d) begin
			if (addr_d == `DDSR_ADDR_DOS)
				o_rdata <= dos_snap;
			else if (addr_d == `DDSR_ADDR_GFI)
				o_rdata <= gfi_snap;
			else if (addr_d >= `DDSR_ADDR_CF1 && addr_d <= `DDSR_ADDR_CF6)
				o_rdata <= ddsr_par({(addr_d == `DDSR_ADDR_CF1) & aux_snap,
					4'h0, fb_rdata});
			else
				o_rdata <= ddsr_par(15'h0000);
		end
	end
endmodule
`default_nettype wire

//--- sim/ddsr_checker_properties.sv
// port-level assertions for the diagnostic register bank
`timescale 1ns/1ps
`default_nettype none
module ddsr_checker (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_rd,
	input wire logic i_rc,
	input wire logic [5:0] i_addr,
	input wire logic [15:0] o_rdata,
	input wire logic i_logic_uv,
	input wire logic o_global_supply_fault,
	input wire logic [5:0] i_tsd_set,
	input wire logic i_scope_select,
	input wire logic o_device_off,
	input wire logic [5:0] o_out_off,
	input wire logic [1:0] i_ext_on,
	input wire logic [1:0] o_ext_off
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	// ==========================================
	// read path
	parity_odd_a: assert property ((i_rd || i_rc) |-> ##3 ^o_rdata)
		else $error("read word parity is even");
	unmapped_zero_a: assert property ((i_rd && (i_addr < 6'h11 || i_addr > 6'h1C)) ##1
		(!(i_rd || i_rc)) [*2] |=> o_rdata == 16'h0001) else $error("unmapped read not 0001");
	rdata_holds_a: assert property ((!(i_rd || i_rc)) [*3] |=> $stable(o_rdata))
		else $error("read data moved without request");
	// ==========================================
	// latched faults
	uv_global_a: assert property (i_logic_uv [*4] |=> o_global_supply_fault)
		else $error("supply fault flag missing");
	global_hold_a: assert property (o_global_supply_fault && !i_rc |=> o_global_supply_fault)
		else $error("supply fault flag dropped without clear");
	device_off_a: assert property ((i_scope_select && i_tsd_set != 6'h00) [*4] |=> o_device_off)
		else $error("device not disabled on shutdown");
	output_off_a: assert property ((!i_scope_select && i_tsd_set[2]) [*4] |=> o_out_off[2])
		else $error("output not disabled on shutdown");
	// a clear lands on the flag one cycle before the registered output drops
	off_latched_a: assert property (o_out_off != 6'h00 && !i_rc && !$past(i_rc) |=>
		i_scope_select || (o_out_off & $past(o_out_off)) == $past(o_out_off))
		else $error("output off released");
	blank_quiet_a: assert property ($rose(i_ext_on[0]) |-> (!o_ext_off[0]) [*8])
		else $error("external fault inside blanking");
endmodule
`default_nettype wire

//--- sim/ddsr_host_model.sv
// host model: framed register requests and feedback decoding
`timescale 1ns/1ps
`default_nettype none
module ddsr_host (
	input wire logic i_clk,
	input wire logic [15:0] i_rdata,
	output logic o_csn,
	output logic o_rd,
	output logic o_rc,
	output logic o_wr,
	output logic [5:0] o_addr,
	output logic [15:0] o_mask
);
	initial begin
		{o_rd, o_rc, o_wr, o_addr, o_mask} = '0;
		o_csn = 1'b1;
	end
	// parity dropped, aux flag in bit 15 masked off
	function automatic logic [9:0] fb_count(input logic [15:0] wd);
		return wd[10:1];
	endfunction
	// csn falls first so the levels are frozen before the request
	task automatic xfer(input logic [1:0] k, input logic [5:0] a, input logic [15:0] m,
		output logic [15:0] d);
		@(posedge i_clk) #1 o_csn = 1'b0;
		repeat (4) @(posedge i_clk);
		#1 {o_rd, o_rc, o_wr} = {k == 2'h0, k == 2'h1, k == 2'h2};
		{o_addr, o_mask} = {a, m};
		@(posedge i_clk) #1 {o_rd, o_rc, o_wr} = 3'h0;
		// released address shows the inverted address, not the old value
		o_addr = ~a;
		repeat (2) @(posedge i_clk);
		#1 d = i_rdata;
		o_csn = 1'b1;
	endtask
endmodule
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench for the diagnostic register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic i_clk = 1'b0;
	logic i_nrst, i_csn, i_rd, i_rc, i_wr, i_emerg_override, i_seq_active, i_seq_braking;
	logic i_seq_done, i_logic_uv, i_aux_uv, i_bat_ov, i_bat_lvi, i_pump_low, i_scope_select;
	logic i_fb_we, o_global_supply_fault, o_device_off;
	logic [1:0] i_ext_on, i_ext_vds_hi, i_ext_vds_side, i_ext_level, i_brake_setting, o_ext_off;
	logic [5:0] i_addr, i_out_level, i_override, i_tw_set, i_tw_hold, i_tsd_set, i_tsd_hold;
	logic [5:0] o_out_off;
	logic [3:0] i_blank_setting;
	logic [2:0] i_fb_sel;
	logic [9:0] i_fb_value;
	logic [15:0] i_rc_mask, o_rdata, r;
	logic [31:0] seed, v;
	int fails = 0;
	int tests_run = 0;
	int i;
	always #2.5 i_clk = ~i_clk;
	ddsr_top #(.DONE_CYCLES(50)) u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_csn(i_csn),
		.i_rd(i_rd), .i_rc(i_rc), .i_wr(i_wr), .i_addr(i_addr), .i_rc_mask(i_rc_mask),
		.o_rdata(o_rdata), .i_ext_on(i_ext_on), .i_ext_vds_hi(i_ext_vds_hi),
		.i_ext_vds_side(i_ext_vds_side), .i_blank_setting(i_blank_setting),
		.i_ext_level(i_ext_level), .i_out_level(i_out_level), .i_override(i_override),
		.i_emerg_override(i_emerg_override), .i_seq_active(i_seq_active),
		.i_seq_braking(i_seq_braking), .i_seq_done(i_seq_done), .i_brake_setting(i_brake_setting),
		.i_logic_uv(i_logic_uv), .i_aux_uv(i_aux_uv), .i_bat_ov(i_bat_ov), .i_bat_lvi(i_bat_lvi),
		.i_pump_low(i_pump_low), .i_tw_set(i_tw_set), .i_tw_hold(i_tw_hold), .i_tsd_set(i_tsd_set),
		.i_tsd_hold(i_tsd_hold), .i_scope_select(i_scope_select), .i_fb_we(i_fb_we),
		.i_fb_sel(i_fb_sel), .i_fb_value(i_fb_value), .o_global_supply_fault(o_global_supply_fault),
		.o_ext_off(o_ext_off), .o_out_off(o_out_off), .o_device_off(o_device_off));
	ddsr_host h (.i_clk(i_clk), .i_rdata(o_rdata), .o_csn(i_csn), .o_rd(i_rd), .o_rc(i_rc),
		.o_wr(i_wr), .o_addr(i_addr), .o_mask(i_rc_mask));
	// ==========================================
	// helpers
	function automatic logic [15:0] w(input logic [15:1] d);
		return {d, ~^d};
	endfunction
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic op(input logic [1:0] k, input logic [5:0] a, input logic [15:0] m, e);
		h.xfer(k, a, m, r);
		chk(r, e);
	endtask
	task automatic seq(input logic [2:0] s, input logic [1:0] st);
		@(posedge i_clk) #1 {i_seq_active, i_seq_braking, i_seq_done} = s;
		repeat (3) @(posedge i_clk);
		op(2'h0, 6'h11, 16'h0, w({1'b0, st, 12'h0}));
	endtask
	task automatic summarize();
		if (fails == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#100000;
		fails++;
		summarize();
	end
	// ==========================================
	// scenarios
	initial begin
		seed = 32'h056D;
		{i_nrst, i_emerg_override, i_seq_active, i_seq_braking, i_seq_done, i_logic_uv, i_aux_uv,
			i_bat_ov, i_bat_lvi, i_pump_low, i_scope_select, i_fb_we, i_ext_on, i_ext_vds_hi,
			i_ext_vds_side, i_ext_level, i_brake_setting, i_out_level, i_override, i_tw_set,
			i_tw_hold, i_tsd_set, i_tsd_hold, i_blank_setting, i_fb_sel, i_fb_value} = '0;
		repeat (6) @(posedge i_clk);
		#1 i_nrst = 1'b1;
		for (i = 5; i < 25; i += (i == 5) ? 12 : 1)
			op(2'h0, 6'(i), 16'h0, 16'h0001);
		v = $random(seed);
		{i_pump_low, i_bat_lvi, i_bat_ov, i_logic_uv, i_aux_uv} = 5'h1F;
		{i_tw_set, i_tw_hold} = {2{v[5:0]}};
		repeat (4) @(posedge i_clk);
		#1 {i_pump_low, i_bat_lvi, i_bat_ov, i_logic_uv, i_aux_uv, i_tw_set} = '0;
		chk(16'(o_global_supply_fault), 16'h0001);
		op(2'h1, 6'h12, 16'hFFFF, w({3'h7, 6'h0, v[5:0]}));
		op(2'h1, 6'h12, 16'hFFFF, w({9'h0, v[5:0]}));
		i_tw_hold = 6'h00;
		op(2'h1, 6'h12, 16'hFFFF, w({9'h0, v[5:0]}));
		op(2'h0, 6'h12, 16'h0, 16'h0001);
		op(2'h1, 6'h13, 16'hFFFF, w({1'b1, 14'h0}));
		op(2'h1, 6'h11, 16'hFFFF, w({1'b1, 14'h0}));
		chk(16'(o_global_supply_fault), 16'h0000);
		for (i = 0; i < 6; i++) begin
			v = $random(seed);
			{i_fb_we, i_fb_sel, i_fb_value} = {1'b1, i[2:0], v[9:0]};
			@(posedge i_clk) #1 i_fb_we = 1'b0;
			op(2'h1, 6'(19 + i), 16'hFFFF, w({5'h0, v[9:0]}));
			chk({6'h0, h.fb_count(r)}, {6'h0, v[9:0]});
		end
		v = $random(seed);
		{i_ext_level, i_out_level} = v[7:0];
		fork
			op(2'h0, 6'h11, 16'h0, w({3'h0, v[7:0], 4'h0}));
			begin
				repeat (5) @(posedge i_clk);
				#1 {i_ext_level, i_out_level} = ~v[7:0];
			end
		join
		{i_ext_level, i_out_level} = 8'h00;
		{i_tsd_set, i_tsd_hold} = {2{6'h04}};
		repeat (6) @(posedge i_clk);
		#1 {i_tsd_set, i_tsd_hold} = 12'h000;
		repeat (4) @(posedge i_clk);
		#1 chk({o_device_off, 9'h0, o_out_off}, 16'h0004);
		op(2'h1, 6'h12, 16'hFFFF, w({3'h0, 6'h04, 6'h0}));
		chk(16'(o_out_off), 16'h0000);
		{i_scope_select, i_tsd_set} = 7'h41;
		repeat (6) @(posedge i_clk);
		#1 chk(16'(o_device_off), 16'h0001);
		i_tsd_set = 6'h00;
		op(2'h1, 6'h12, 16'hFFFF, w({8'h0, 1'b1, 6'h0}));
		for (i = 0; i < 2; i++) begin
			i_blank_setting = i ? 4'hF : 4'h0;
			{i_ext_on, i_ext_vds_hi, i_ext_vds_side} = 6'h3E;
			repeat (i * 96 + 8) @(posedge i_clk);
			#1 chk(16'(o_ext_off), 16'h0000);
			repeat (40) @(posedge i_clk);
			#1 chk(16'(o_ext_off), 16'h0003);
			{i_ext_on, i_ext_vds_hi} = 4'h0;
			op(2'h1, 6'h11, 16'h001E, w(15'h0009));
		end
		seq(3'h4, 2'h1);
		seq(3'h2, 2'h2);
		seq(3'h1, 2'h3);
		seq(3'h0, 2'h3);
		op(2'h1, 6'h11, 16'h6000, w(15'h3000));
		seq(3'h0, 2'h0);
		i_brake_setting = 2'h3;
		seq(3'h4, 2'h1);
		seq(3'h2, 2'h2);
		repeat (60) @(posedge i_clk);
		seq(3'h0, 2'h3);
		op(2'h1, 6'h11, 16'h6000, w(15'h3000));
		seq(3'h4, 2'h1);
		{i_seq_active, i_emerg_override} = 2'h1;
		h.xfer(2'h2, 6'h01, 16'h0, r);
		op(2'h0, 6'h11, 16'h0, 16'h0001);
		{i_emerg_override, i_override} = 7'h3F;
		seq(3'h4, 2'h0);
		summarize();
	end
endmodule
bind ddsr_top ddsr_checker u_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_rd(i_rd), .i_rc(i_rc),
	.i_addr(i_addr), .o_rdata(o_rdata), .i_logic_uv(i_logic_uv), .i_tsd_set(i_tsd_set),
	.o_global_supply_fault(o_global_supply_fault), .i_scope_select(i_scope_select),
	.o_device_off(o_device_off), .o_out_off(o_out_off), .i_ext_on(i_ext_on), .o_ext_off(o_ext_off));
`default_nettype wire
